// ### tb/ofs_fault_src.sv
// Fault source model driving the six fault levels
`default_nettype none
module ofs_fault_src (input wire logic core_clk,
    input wire logic [5:0] want, output var logic [5:0] fault);
    timeunit 1ns / 1ps;
    always @(posedge core_clk) fault <= want;
endmodule // ofs_fault_src
`default_nettype wire

// ### tb/ofs_status_regs_properties.sv
// Port checks for the output fault status registers
`default_nettype none
module ofs_props (input wire logic core_clk, reset, short_fault,
    overvolt_fault, powerup_timeout, overcurrent_fault, reg_read, irq,
    input wire logic [7:0] reg_addr, input wire logic [15:0] reg_rdata);
    timeunit 1ns / 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic rd_v = reg_read && reg_addr == 8'h72;
    wire logic rd_i = reg_read && reg_addr == 8'h73;
    wire logic [15:0] fv = {short_fault, 7'h0, overvolt_fault, 4'h0,
        powerup_timeout, 2'h0};
    wire logic [15:0] fi = {8'h0, overcurrent_fault, 7'h0};
    chk_reset_clear: assert property ($fell(reset) |->
        !irq && reg_rdata == 16'h0) else $error("Reset not clean");
    chk_idle_zero: assert property (!reg_read |=>
        reg_rdata == 16'h0) else $error("Data without read");
    chk_vout_spare: assert property (rd_v |=>
        (reg_rdata & 16'h7f6b) == 16'h0) else $error("Voltage spare set");
    chk_iout_spare: assert property (rd_i |=>
        (reg_rdata & 16'hff3f) == 16'h0) else $error("Current spare set");
    chk_vout_set: assert property (rd_v |=>
        (~reg_rdata & $past(fv, 5)) == 16'h0) else $error("Voltage flag lost");
    chk_iout_set: assert property (rd_i |=>
        (~reg_rdata & $past(fi, 5)) == 16'h0) else $error("Current flag lost");
endmodule // ofs_props
bind ofs_status_regs ofs_props u_props (.*);
`default_nettype wire

// ### tb/output_fault_status_regs_tb_top.sv
// Bench for the output fault status registers
`default_nettype none
module output_fault_status_regs_tb_top;
    timeunit 1ns / 1ps;
    logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0, irq, mode;
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [5:0] want = 0, f, fl, st, g, m;
    integer fails = 0, compares = 0, seed = 32'h42e05f1f, i, r;
    always #20 core_clk = ~core_clk;
    ofs_fault_src u_src (.core_clk(core_clk), .want(want), .fault(f));
    ofs_status_regs u_dut (.core_clk(core_clk), .reset(reset),
        .short_fault(f[0]), .overvolt_fault(f[1]), .undervolt_fault(f[2]),
        .powerup_timeout(f[3]), .overcurrent_fault(f[4]),
        .overpower_fault(f[5]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .irq(irq));
    task chk(input string n, input logic [15:0] s, e);
        compares += 1;
        if (s !== e) begin
            fails += 1;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task acc(input logic [7:0] a, input logic [15:0] d, input logic w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= w;
        reg_read <= !w;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1 if (!w) chk("reg_rdata", reg_rdata, d);
    endtask
    task wrap_up;
        $display("Compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000 fails += 1;
        wrap_up;
    end
    initial begin
        for (r = 0; r < 2; r++) begin
            @(posedge core_clk) reset <= 1'b1;
            repeat (3) @(posedge core_clk);
            reset <= 1'b0;
            {fl, st} = 0;
            for (i = 8'h71; i < 8'h74; i++) begin
                acc(i[7:0], 16'hffff, 1);
                acc(i[7:0], 16'h0000, 0);
            end
            acc(8'h82, 16'h0001, 0);
            for (i = 0; i < 12; i++) begin
                g = $random(seed);
                m = $random(seed);
                mode = $random(seed);
                acc(8'h82, {15'h0, mode}, 1);
                acc(8'h81, {10'h0, m}, 1);
                @(posedge core_clk) want <= g;
                repeat (4) @(posedge core_clk);
                want <= 6'h00;
                repeat (4) @(posedge core_clk);
                g = g & (mode ? 6'h3b : 6'h1f);
                st = st | (g & ~fl);
                fl = fl | g;
                acc(8'h72, 16'h0000, 1);
                acc(8'h73, 16'h0000, 1);
                acc(8'h72,
                    {fl[0], 7'h0, fl[1], 2'h0, fl[2], 1'b0, fl[3], 2'h0}, 0);
                acc(8'h73, {8'h0, fl[4], fl[5], 6'h0}, 0);
                acc(8'h80, {10'h0, st}, 0);
                chk("irq", irq, (st & m) != 0);
                g = $random(seed);
                acc(8'h80, {10'h0, g}, 1);
                st = st & ~g;
            end
            $display("Pass %0d done", r);
        end
        wrap_up;
    end
endmodule // output_fault_status_regs_tb_top
`default_nettype wire

// ### verilog/ofs_map.vh
// Register map and field layout of the output fault status block
`ifndef OFS_MAP_VH
`define OFS_MAP_VH
`define OFS_ADDR_W          8
`define OFS_VOUT_STATUS     8'h72
`define OFS_IOUT_STATUS     8'h73
`define OFS_IRQ_STATUS      8'h80
`define OFS_IRQ_MASK        8'h81
`define OFS_MODE_CTRL       8'h82
`define OFS_VOUT_SHORT_BIT  15
`define OFS_VOUT_OV_BIT     7
`define OFS_VOUT_UV_BIT     4
`define OFS_VOUT_TON_BIT    2
`define OFS_IOUT_OC_BIT     7
`define OFS_IOUT_OP_BIT     6
`define OFS_IRQ_W           6
`define OFS_IRQ_RESET       6'h00
`define OFS_MASK_RESET      6'h00
`define OFS_MODE_RESET      1'b1
`define OFS_FLAG_RESET      16'h0000
`define OFS_MODE_VSRC       1'b0
`define OFS_MODE_ISRC       1'b1
`endif

// ### verilog/ofs_status_regs.v
// Output fault status registers with sticky flags and interrupt
//
// Operation
// - Short circuit sets voltage bit 15, overvoltage sets bit 7.
// - Undervoltage sets voltage bit 4 only in voltage-source mode.
// - Missed target by power-up time end sets voltage bit 2.
// - Overcurrent sets current bit 7; overpower bit 6 in current mode.
// - Fault flags stay latched until power recycle; access never clears.
//
// Our own choice: strobed register access.
`include "ofs_map.vh"
`default_nettype none
module ofs_status_regs (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        short_fault,
    input  wire        overvolt_fault,
    input  wire        undervolt_fault,
    input  wire        powerup_timeout,
    input  wire        overcurrent_fault,
    input  wire        overpower_fault,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    output reg         irq
);
    wire [5:0]  fault_sync;
    reg  [15:0] vout_status_reg;
    reg  [15:0] vout_status_next;
    reg  [15:0] iout_status_reg;
    reg  [15:0] iout_status_next;
    reg  [5:0]  irq_status_reg;
    reg  [5:0]  irq_status_next;
    reg  [5:0]  irq_mask_reg;
    reg         mode_reg;
    reg  [5:0]  event_pulse;
    reg  [15:0] rdata_next;

    ofs_sync #(
        .W (6)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({overpower_fault, overcurrent_fault, powerup_timeout,
                    undervolt_fault, overvolt_fault, short_fault}),
        .sync_out (fault_sync)
    );

    // Flag set logic; nothing here ever clears a flag
    always @* begin
        vout_status_next = vout_status_reg;
        iout_status_next = iout_status_reg;
        if (fault_sync[0])
            vout_status_next[`OFS_VOUT_SHORT_BIT] = 1'b1;
        if (fault_sync[1])
            vout_status_next[`OFS_VOUT_OV_BIT] = 1'b1;
        if (fault_sync[2] && mode_reg == `OFS_MODE_VSRC)
            vout_status_next[`OFS_VOUT_UV_BIT] = 1'b1;
        if (fault_sync[3])
            vout_status_next[`OFS_VOUT_TON_BIT] = 1'b1;
        if (fault_sync[4])
            iout_status_next[`OFS_IOUT_OC_BIT] = 1'b1;
        if (fault_sync[5] && mode_reg == `OFS_MODE_ISRC)
            iout_status_next[`OFS_IOUT_OP_BIT] = 1'b1;
    end

    // New flag rising edges become interrupt events
    always @* begin
        event_pulse[0] = vout_status_next[`OFS_VOUT_SHORT_BIT]
                       & ~vout_status_reg[`OFS_VOUT_SHORT_BIT];
        event_pulse[1] = vout_status_next[`OFS_VOUT_OV_BIT]
                       & ~vout_status_reg[`OFS_VOUT_OV_BIT];
        event_pulse[2] = vout_status_next[`OFS_VOUT_UV_BIT]
                       & ~vout_status_reg[`OFS_VOUT_UV_BIT];
        event_pulse[3] = vout_status_next[`OFS_VOUT_TON_BIT]
                       & ~vout_status_reg[`OFS_VOUT_TON_BIT];
        event_pulse[4] = iout_status_next[`OFS_IOUT_OC_BIT]
                       & ~iout_status_reg[`OFS_IOUT_OC_BIT];
        event_pulse[5] = iout_status_next[`OFS_IOUT_OP_BIT]
                       & ~iout_status_reg[`OFS_IOUT_OP_BIT];
    end

    // Write one to clear; a new event wins over the clear
    always @* begin
        irq_status_next = irq_status_reg;
        if (reg_write && reg_addr == `OFS_IRQ_STATUS)
            irq_status_next = irq_status_next & ~reg_wdata[5:0];
        irq_status_next = irq_status_next | event_pulse;
    end

    // Read mux; spare bits and unmapped addresses read zero
    always @* begin
        rdata_next = 16'h0000;
        case (reg_addr)
            `OFS_VOUT_STATUS: rdata_next = vout_status_reg;
            `OFS_IOUT_STATUS: rdata_next = iout_status_reg;
            `OFS_IRQ_STATUS:  rdata_next = {10'h000, irq_status_reg};
            `OFS_IRQ_MASK:    rdata_next = {10'h000, irq_mask_reg};
            `OFS_MODE_CTRL:   rdata_next = {15'h0000, mode_reg};
            default:          rdata_next = 16'h0000;
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            vout_status_reg <= `OFS_FLAG_RESET;
            iout_status_reg <= `OFS_FLAG_RESET;
            irq_status_reg  <= `OFS_IRQ_RESET;
            irq_mask_reg    <= `OFS_MASK_RESET;
            mode_reg        <= `OFS_MODE_RESET;
            reg_rdata       <= 16'h0000;
            irq             <= 1'b0;
        end else begin
            vout_status_reg <= vout_status_next;
            iout_status_reg <= iout_status_next;
            irq_status_reg  <= irq_status_next;
            if (reg_write && reg_addr == `OFS_IRQ_MASK)
                irq_mask_reg <= reg_wdata[5:0];
            if (reg_write && reg_addr == `OFS_MODE_CTRL)
                mode_reg <= reg_wdata[0];
            reg_rdata <= reg_read ? rdata_next : 16'h0000;
            irq       <= |(irq_status_next & irq_mask_reg);
        end
    end
endmodule // ofs_status_regs
`default_nettype wire

// ### verilog/ofs_sync.v
// Two-stage synchroniser for a group of asynchronous fault inputs
`default_nettype none
module ofs_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         reset,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;

    always @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // ofs_sync
`default_nettype wire
